// *** design/sbr_pkg.sv ***
// Notes on behaviour
// - first-generation sync bus inputs toggle no faster than 1 kHz
// - first-generation bus pulse seen only if held at least 100 us
// - first-generation card refuses bus input driven by second generation
// - fast-port-only first generation: four bus inputs and four outputs
// - first generation with slow port: two bus inputs, three outputs
// - first-generation backplane form factor lacks general line 6
// - transceiver event: port one to even lines, port two to odd
// - desktop-bus second generation lacks backplane star and ref clock
// - pc-card second generation lacks oscillator output, star and clock
// - pc-card parts lack general lines 4, 5 and 6
// - general line source drives only realign clock or start trigger
// - gen two: clock line and ref clock drive timebase; star to start
// - realign clock drives general line or start; start event to line
// - gen two: oscillator to clock line; receive and transceiver events
// - legality judged per generation with a validity mark per pair
// - unconnected master timebase falls back to local oscillator
// - start trigger fires on first rising edge of its source
// - each realign clock rising edge aligns the local timebase
package sbr_pkg;

	// source terminal codes
	localparam logic [3:0] SRC_LINE     = 4'h0;
	localparam logic [3:0] SRC_CLKLINE  = 4'h1;
	localparam logic [3:0] SRC_STAR     = 4'h2;
	localparam logic [3:0] SRC_REFCLK   = 4'h3;
	localparam logic [3:0] SRC_OSC      = 4'h4;
	localparam logic [3:0] SRC_REALIGN  = 4'h5;
	localparam logic [3:0] SRC_RXEV     = 4'h6;
	localparam logic [3:0] SRC_XCVREV   = 4'h7;
	localparam logic [3:0] SRC_STARTEV  = 4'h8;
	// destination terminal codes
	localparam logic [2:0] DST_LINE     = 3'h0;
	localparam logic [2:0] DST_CLKLINE  = 3'h1;
	localparam logic [2:0] DST_TIMEBASE = 3'h2;
	localparam logic [2:0] DST_REALIGN  = 3'h3;
	localparam logic [2:0] DST_START    = 3'h4;

	localparam logic [1:0] FF_DESKTOP   = 2'h0;
	localparam logic [1:0] FF_BACKPLANE = 2'h1;
	localparam logic [1:0] FF_PCCARD    = 2'h2;

	// line-count limits for first generation
	localparam logic [2:0] FAST_IN_MAX  = 3'h4;
	localparam logic [2:0] FAST_OUT_MAX = 3'h4;
	localparam logic [2:0] SLOW_IN_MAX  = 3'h2;
	localparam logic [2:0] SLOW_OUT_MAX = 3'h3;

	// register offsets (APB byte addresses)
	localparam logic [7:0] OFF_CFG      = 8'h00;
	localparam logic [7:0] OFF_CMD      = 8'h04;
	localparam logic [7:0] OFF_STATUS   = 8'h08;
	localparam logic [7:0] OFF_LINE_IN  = 8'h0C;
	localparam logic [7:0] OFF_LINE_OUT = 8'h10;

	// cfg fields
	localparam int CFG_GEN2_BIT  = 0;
	localparam int CFG_SLOW_BIT  = 1;
	localparam int CFG_PORT2_BIT = 2;
	localparam int CFG_FF_LSB    = 4;
	localparam logic [31:0] CFG_RESET = 32'h0000_0000;
	// cmd fields: [3:0] src, [6:4] src line, [10:8] dst, [14:12] dst line,
	// [16] 1=connect 0=disconnect
	localparam int CMD_SRC_LSB  = 0;
	localparam int CMD_SLN_LSB  = 4;
	localparam int CMD_DST_LSB  = 8;
	localparam int CMD_DLN_LSB  = 12;
	localparam int CMD_CONN_BIT = 16;

	// timing
	localparam real CLK_NS         = 5.0;
	localparam real MIN_PULSE_US   = 100.0;
	localparam real MIN_PERIOD_US  = 1000.0;
	localparam int  MIN_PULSE_CYC  = int'($ceil(MIN_PULSE_US * 1000.0 / CLK_NS));
	localparam int  MIN_PERIOD_CYC = int'($ceil(MIN_PERIOD_US * 1000.0 / CLK_NS));

	typedef struct packed {
		logic [3:0] src;
		logic [2:0] src_line;
		logic [2:0] dst;
		logic [2:0] dst_line;
		logic       connect;
	} sbr_cmd_t;

endpackage : sbr_pkg

// *** design/sbr_router.sv ***
`timescale 1ns/10ps
`default_nettype none
module sbr_router #(
	parameter int PULSE_CYC  = sbr_pkg::MIN_PULSE_CYC,
	parameter int PERIOD_CYC = sbr_pkg::MIN_PERIOD_CYC
) (
	input  wire logic        I_CORE_CLK,
	input  wire logic        I_RESET,
	input  wire logic        PSEL,
	input  wire logic        PENABLE,
	input  wire logic        PWRITE,
	input  wire logic [7:0]  PADDR,
	input  wire logic [31:0] PWDATA,
	output logic      [31:0] PRDATA,
	output logic             PREADY,
	output logic             PSLVERR,
	input  wire logic [7:0]  I_SYNC_LINE,
	input  wire logic        I_STAR,
	input  wire logic        I_REF_CLK,
	input  wire logic        I_OSC,
	input  wire logic        I_RX_EVENT,
	input  wire logic        I_XCVR_EVENT,
	output logic      [7:0]  O_SYNC_LINE,
	output logic      [7:0]  O_SYNC_LINE_OE_N,
	output logic             O_TIMEBASE,
	output logic             O_TIMEBASE_EXT,
	output logic             O_REALIGN,
	output logic             O_START
);

	// ****************************************************
	// pin synchronisers
	// ****************************************************
	logic [12:0] meta_q;
	logic [12:0] sync_q;
	always_ff @(posedge I_CORE_CLK) begin
		meta_q <= {I_OSC, I_XCVR_EVENT, I_RX_EVENT, I_REF_CLK, I_STAR,
			I_SYNC_LINE};
		sync_q <= meta_q;
	end
	wire logic [7:0] line_s = sync_q[7:0];
	wire logic star_s = sync_q[8];
	wire logic ref_s  = sync_q[9];
	wire logic rx_s   = sync_q[10];
	wire logic xcvr_s = sync_q[11];
	wire logic osc_s  = sync_q[12];

	// ****************************************************
	// registers
	// ****************************************************
	logic [31:0] cfg_q;
	logic [7:0]  line_in_q;
	logic [7:0]  line_out_q;
	logic [3:0]  out_src_q [0:7];
	logic [2:0]  tb_src_q;
	logic [2:0]  re_src_q;
	logic [2:0]  st_src_q;
	logic [2:0]  re_line_q;
	logic [2:0]  st_line_q;
	logic        err_q;

	wire logic gen2  = cfg_q[sbr_pkg::CFG_GEN2_BIT];
	wire logic slow  = cfg_q[sbr_pkg::CFG_SLOW_BIT];
	wire logic port2 = cfg_q[sbr_pkg::CFG_PORT2_BIT];
	wire logic [1:0] ff = cfg_q[sbr_pkg::CFG_FF_LSB +: 2];

	function automatic logic [2:0] popcnt(input logic [7:0] v);
		logic [2:0] n;
		n = 3'h0;
		for (int k = 0; k < 7; k++) begin
			n = n + {2'h0, v[k]};
		end
		return n;
	endfunction : popcnt

	// line available on this card (general lines only)
	function automatic logic line_ok(input logic [2:0] ln,
		input logic g2, input logic [1:0] f);
		logic ok;
		ok = (ln != 3'h7);
		// backplane gen one lacks line 6
		if (!g2 && f == sbr_pkg::FF_BACKPLANE && ln == 3'h6)
			ok = 1'b0;
		// pc-card lacks lines 4 to 6
		if (f == sbr_pkg::FF_PCCARD && ln >= 3'h4)
			ok = 1'b0;
		return ok;
	endfunction : line_ok

	sbr_pkg::sbr_cmd_t cmd;
	logic legal;
	always_comb begin
		cmd.src      = PWDATA[sbr_pkg::CMD_SRC_LSB +: 4];
		cmd.src_line = PWDATA[sbr_pkg::CMD_SLN_LSB +: 3];
		cmd.dst      = PWDATA[sbr_pkg::CMD_DST_LSB +: 3];
		cmd.dst_line = PWDATA[sbr_pkg::CMD_DLN_LSB +: 3];
		cmd.connect  = PWDATA[sbr_pkg::CMD_CONN_BIT];
		legal = 1'b0;
		unique case (cmd.src)
			// general line only to realign or start
			sbr_pkg::SRC_LINE:
				legal = (cmd.dst == sbr_pkg::DST_REALIGN
					|| cmd.dst == sbr_pkg::DST_START)
					&& line_ok(cmd.src_line, gen2, ff)
					// gen one refuses fast bus input
					&& !(!gen2 && PWDATA[31]);
			sbr_pkg::SRC_CLKLINE:
				legal = gen2 && cmd.dst == sbr_pkg::DST_TIMEBASE;
			sbr_pkg::SRC_STAR:
				legal = gen2 && cmd.dst == sbr_pkg::DST_START
					&& ff == sbr_pkg::FF_BACKPLANE;
			// star and ref clock only on backplane
			sbr_pkg::SRC_REFCLK:
				legal = gen2 && cmd.dst == sbr_pkg::DST_TIMEBASE
					&& ff == sbr_pkg::FF_BACKPLANE;
			// oscillator to clock line; not on pc-card
			sbr_pkg::SRC_OSC:
				legal = gen2 && cmd.dst == sbr_pkg::DST_CLKLINE
					&& ff != sbr_pkg::FF_PCCARD;
			sbr_pkg::SRC_REALIGN:
				legal = cmd.dst == sbr_pkg::DST_START
					|| (cmd.dst == sbr_pkg::DST_LINE
					&& line_ok(cmd.dst_line, gen2, ff));
			sbr_pkg::SRC_RXEV:
				legal = gen2 && (cmd.dst == sbr_pkg::DST_START
					|| (cmd.dst == sbr_pkg::DST_LINE
					&& line_ok(cmd.dst_line, gen2, ff)));
			sbr_pkg::SRC_XCVREV:
				legal = gen2 && cmd.dst == sbr_pkg::DST_LINE
					&& line_ok(cmd.dst_line, gen2, ff)
					&& (cmd.dst_line[0] == port2);
			sbr_pkg::SRC_STARTEV:
				legal = cmd.dst == sbr_pkg::DST_LINE
					&& line_ok(cmd.dst_line, gen2, ff);
			default:
				legal = 1'b0;
		endcase
		if (!gen2 && cmd.connect) begin
			if (cmd.src == sbr_pkg::SRC_LINE && !line_in_q[cmd.src_line]
				&& popcnt(line_in_q) >= (slow ? sbr_pkg::SLOW_IN_MAX
				: sbr_pkg::FAST_IN_MAX))
				legal = 1'b0;
			if (cmd.dst == sbr_pkg::DST_LINE && !line_out_q[cmd.dst_line]
				&& popcnt(line_out_q) >= (slow ? sbr_pkg::SLOW_OUT_MAX
				: sbr_pkg::FAST_OUT_MAX))
				legal = 1'b0;
		end
	end

	wire logic acc   = PSEL && PENABLE && !PREADY;
	wire logic wr    = acc && PWRITE;
	wire logic cmd_w = wr && PADDR == sbr_pkg::OFF_CMD;

	// ****************************************************
	// bus slave
	// ****************************************************
	// one wait state: answer on second access cycle
	always_ff @(posedge I_CORE_CLK) begin
		if (I_RESET) begin
			PREADY  <= 1'b0;
			PSLVERR <= 1'b0;
			PRDATA  <= 32'h0000_0000;
			cfg_q   <= sbr_pkg::CFG_RESET;
		end else begin
			PREADY  <= acc;
			PSLVERR <= 1'b0;
			PRDATA  <= 32'h0000_0000;
			if (acc) begin
				unique case (PADDR)
					sbr_pkg::OFF_CFG: PRDATA <= cfg_q;
					sbr_pkg::OFF_CMD: PRDATA <= 32'h0000_0000;
					sbr_pkg::OFF_STATUS:
						PRDATA <= {24'h0, O_START, O_REALIGN,
							tb_src_q != 3'h0, 4'h0, err_q};
					sbr_pkg::OFF_LINE_IN: PRDATA <= {24'h0, line_in_q};
					sbr_pkg::OFF_LINE_OUT: PRDATA <= {24'h0, line_out_q};
					default: PSLVERR <= 1'b1;
				endcase
				if (wr && PADDR == sbr_pkg::OFF_CFG)
					cfg_q <= PWDATA;
				// illegal request flagged as bus error
				if (cmd_w && cmd.connect && !legal)
					PSLVERR <= 1'b1;
			end
		end
	end

	// ****************************************************
	// routing table
	// ****************************************************
	always_ff @(posedge I_CORE_CLK) begin
		if (I_RESET) begin
			err_q      <= 1'b0;
			line_in_q  <= 8'h00;
			line_out_q <= 8'h00;
			tb_src_q   <= 3'h0;
			re_src_q   <= 3'h0;
			st_src_q   <= 3'h7;
			re_line_q  <= 3'h0;
			st_line_q  <= 3'h0;
			for (int k = 0; k < 8; k++)
				out_src_q[k] <= 4'hF;
		end else if (cmd_w && !cmd.connect) begin
			err_q <= 1'b0;
			if (cmd.dst == sbr_pkg::DST_LINE) begin
				out_src_q[cmd.dst_line] <= 4'hF;
				line_out_q[cmd.dst_line] <= 1'b0;
			end
			if (cmd.dst == sbr_pkg::DST_CLKLINE)
				out_src_q[7] <= 4'hF;
			if (cmd.dst == sbr_pkg::DST_TIMEBASE)
				tb_src_q <= 3'h0;
			if (cmd.dst == sbr_pkg::DST_REALIGN)
				re_src_q <= 3'h0;
			if (cmd.dst == sbr_pkg::DST_START)
				st_src_q <= 3'h7;
			if (cmd.src == sbr_pkg::SRC_LINE)
				line_in_q[cmd.src_line] <= 1'b0;
		end else if (cmd_w) begin
			err_q <= !legal;
			if (legal) begin
				if (cmd.src == sbr_pkg::SRC_LINE)
					line_in_q[cmd.src_line] <= 1'b1;
				unique case (cmd.dst)
					sbr_pkg::DST_LINE: begin
						out_src_q[cmd.dst_line] <= cmd.src;
						line_out_q[cmd.dst_line] <= 1'b1;
					end
					sbr_pkg::DST_CLKLINE: out_src_q[7] <= cmd.src;
					sbr_pkg::DST_TIMEBASE:
						tb_src_q <= (cmd.src == sbr_pkg::SRC_REFCLK)
							? 3'h2 : 3'h1;
					sbr_pkg::DST_REALIGN: begin
						re_src_q  <= 3'h1;
						re_line_q <= cmd.src_line;
					end
					sbr_pkg::DST_START: begin
						st_src_q  <= cmd.src[2:0];
						st_line_q <= cmd.src_line;
					end
					default: err_q <= 1'b1;
				endcase
			end
		end
	end

	// ****************************************************
	// slow-input qualification for first generation
	// ****************************************************
	// pulse must stay high 100 us; edges spaced 1 ms
	logic [7:0]  qual_q;
	logic [31:0] hi_cnt_q [0:7];
	logic [31:0] gap_cnt_q [0:7];
	always_ff @(posedge I_CORE_CLK) begin
		for (int k = 0; k < 8; k++) begin
			if (I_RESET) begin
				qual_q[k]    <= 1'b0;
				hi_cnt_q[k]  <= 32'h0;
				gap_cnt_q[k] <= 32'h0;
			end else begin
				hi_cnt_q[k] <= line_s[k] ? hi_cnt_q[k] + 32'h1 : 32'h0;
				if (gap_cnt_q[k] < 32'(PERIOD_CYC))
					gap_cnt_q[k] <= gap_cnt_q[k] + 32'h1;
				if (!line_s[k])
					qual_q[k] <= 1'b0;
				else if (hi_cnt_q[k] + 32'h1 >= 32'(PULSE_CYC)
					&& gap_cnt_q[k] >= 32'(PERIOD_CYC) && !qual_q[k]) begin
					qual_q[k]    <= 1'b1;
					gap_cnt_q[k] <= 32'h0;
				end
			end
		end
	end
	wire logic [7:0] line_eff = gen2 ? line_s : qual_q;

	// ****************************************************
	// terminal outputs
	// ****************************************************
	logic realign_src;
	logic start_src;
	logic start_prev_q;
	logic started_q;
	logic realign_prev_q;
	always_comb begin
		realign_src = re_src_q != 3'h0 && line_eff[re_line_q];
		unique case (st_src_q)
			3'h0: start_src = line_eff[st_line_q];
			3'h2: start_src = star_s;
			3'h5: start_src = O_REALIGN;
			3'h6: start_src = rx_s;
			default: start_src = 1'b0;
		endcase
	end

	always_ff @(posedge I_CORE_CLK) begin
		if (I_RESET) begin
			O_REALIGN    <= 1'b0;
			O_START      <= 1'b0;
			O_TIMEBASE   <= 1'b0;
			O_TIMEBASE_EXT <= 1'b0;
			start_prev_q <= 1'b0;
			started_q    <= 1'b0;
			realign_prev_q <= 1'b0;
			O_SYNC_LINE  <= 8'h00;
			O_SYNC_LINE_OE_N <= 8'hFF;
		end else begin
			realign_prev_q <= realign_src;
			O_REALIGN <= realign_src && !realign_prev_q;
			start_prev_q <= start_src;
			// first rising edge only; set wins over the clear
			if (start_src && !start_prev_q)
				started_q <= 1'b1;
			else if (cmd_w)
				started_q <= 1'b0;
			O_START <= started_q;
			O_TIMEBASE_EXT <= tb_src_q != 3'h0;
			O_TIMEBASE <= (tb_src_q == 3'h2) ? ref_s
				: (tb_src_q == 3'h1) ? line_s[7] : osc_s;
			for (int k = 0; k < 8; k++) begin
				O_SYNC_LINE_OE_N[k] <= out_src_q[k] == 4'hF;
				unique case (out_src_q[k])
					sbr_pkg::SRC_OSC:     O_SYNC_LINE[k] <= osc_s;
					sbr_pkg::SRC_REALIGN: O_SYNC_LINE[k] <= O_REALIGN;
					sbr_pkg::SRC_RXEV:    O_SYNC_LINE[k] <= rx_s;
					sbr_pkg::SRC_XCVREV:  O_SYNC_LINE[k] <= xcvr_s;
					sbr_pkg::SRC_STARTEV: O_SYNC_LINE[k] <= started_q;
					default:              O_SYNC_LINE[k] <= 1'b0;
				endcase
			end
		end
	end

endmodule : sbr_router
`default_nettype wire

// *** tb/sbr_router_sva.sv ***
`timescale 1ns/10ps
`default_nettype none
// ************************************************************
// bus answer and routing limit checks
// ************************************************************
module sbr_router_sva (
	input wire logic        I_CORE_CLK,
	input wire logic        I_RESET,
	input wire logic        PSEL,
	input wire logic        PENABLE,
	input wire logic        PWRITE,
	input wire logic [7:0]  PADDR,
	input wire logic [31:0] PWDATA,
	input wire logic        PREADY,
	input wire logic        PSLVERR,
	input wire logic [7:0]  O_SYNC_LINE_OE_N,
	input wire logic        O_TIMEBASE_EXT
);
	logic [7:0] cfg_q;
	default clocking @(posedge I_CORE_CLK);
	endclocking
	default disable iff (I_RESET);
	// shadow of the card setup, limits depend on it
	always_ff @(posedge I_CORE_CLK) begin
		if (I_RESET)
			cfg_q <= 8'h00;
		else if (PSEL && PENABLE && PREADY && PWRITE &&
			PADDR == sbr_pkg::OFF_CFG)
			cfg_q <= PWDATA[7:0];
	end
	sequence s_wait;
		PSEL && PENABLE && !PREADY;
	endsequence
	sequence s_done;
		PSEL && PENABLE && PREADY;
	endsequence
	a_ready_next: assert property (s_wait |=> s_done)
		else $error("answer not one cycle after access");
	a_ready_cause: assert property (PREADY |-> PSEL && PENABLE &&
		$past(PSEL && PENABLE && !PREADY)) else $error("stray ready");
	a_ready_pulse: assert property (PREADY |=> !PREADY)
		else $error("ready held too long");
	a_err_on_ready: assert property (PSLVERR |-> PREADY)
		else $error("error without ready");
	a_refused_hold: assert property (PSLVERR |=>
		$stable(O_SYNC_LINE_OE_N) && $stable(O_TIMEBASE_EXT))
		else $error("refused request changed routing");
	a_fast_limit: assert property (!cfg_q[0] && !cfg_q[1] |->
		$countones(~O_SYNC_LINE_OE_N[6:0]) <= 4)
		else $error("too many outputs, fast ports");
	a_slow_limit: assert property (!cfg_q[0] && cfg_q[1] |->
		$countones(~O_SYNC_LINE_OE_N[6:0]) <= 3)
		else $error("too many outputs, slow port");
	a_line6_absent: assert property (!cfg_q[0] &&
		cfg_q[5:4] == sbr_pkg::FF_BACKPLANE |-> O_SYNC_LINE_OE_N[6])
		else $error("line 6 driven on backplane card");
	a_upper_absent: assert property (cfg_q[5:4] == sbr_pkg::FF_PCCARD
		|-> &O_SYNC_LINE_OE_N[6:4]) else $error("upper lines driven");
	a_gen1_local_tb: assert property (!cfg_q[0] |-> !O_TIMEBASE_EXT)
		else $error("external timebase on first generation");
endmodule : sbr_router_sva
bind sbr_router sbr_router_sva u_sva (
	.I_CORE_CLK      (I_CORE_CLK),
	.I_RESET         (I_RESET),
	.PSEL            (PSEL),
	.PENABLE         (PENABLE),
	.PWRITE          (PWRITE),
	.PADDR           (PADDR),
	.PWDATA          (PWDATA),
	.PREADY          (PREADY),
	.PSLVERR         (PSLVERR),
	.O_SYNC_LINE_OE_N(O_SYNC_LINE_OE_N),
	.O_TIMEBASE_EXT  (O_TIMEBASE_EXT)
);
`default_nettype wire

// *** tb/sbr_bus_peer.sv ***
`timescale 1ns/10ps
`default_nettype none
// ************************************************************
// another card on the sync bus
// ************************************************************
module sbr_bus_peer (
	input  wire logic        i_clk,
	input  wire logic        i_fire,
	input  wire logic [2:0]  i_line,
	input  wire logic [15:0] i_len,
	input  wire logic        i_run,
	output logic      [7:0]  o_line
);
	logic [15:0] cnt_q = 16'h0000;
	logic [2:0]  sel_q = 3'h0;
	logic        lclk  = 1'h0;
	// link clock, free of the core clock phase
	initial begin
		forever #32 lclk = ~lclk;
	end
	// one pulse at a time, held for the asked length
	always_ff @(posedge i_clk) begin
		if (i_fire) begin
			cnt_q <= i_len;
			sel_q <= i_line;
		end else if (cnt_q != 16'h0000) begin
			cnt_q <= cnt_q - 16'h0001;
		end
	end
	// idle lines sit low, terminations pull them down
	assign o_line[6:0] = (cnt_q != 16'h0000) ? 7'(7'h01 << sel_q) : 7'h00;
	// clock line stands still unless a timebase is shared
	assign o_line[7] = i_run & lclk;
endmodule : sbr_bus_peer
`default_nettype wire

// *** tb/testbench.sv ***
`timescale 1ns/10ps
`default_nettype none
// ************************************************************
// routing legality and trigger bench
// ************************************************************
module testbench;
	localparam int PC = 20;
	localparam int PERIOD = 200;
	typedef struct packed {
		logic        err;
		logic        rd;
		logic [31:0] data;
	} sbr_exp_t;
	logic        I_CORE_CLK, I_RESET, PSEL, PENABLE, PWRITE;
	logic [7:0]  PADDR, sync_in, line_out, oe_n, peer_line, cur_cfg;
	logic [31:0] PWDATA, prdata;
	logic        pready, pslverr, star, refclk, osc, rx_ev, xcvr_ev;
	logic        tbase, tb_ext, realign, start, fire, run, tb_seen;
	logic [2:0]  fire_ln;
	logic [15:0] fire_len, lfsr_q;
	sbr_exp_t    exp_q[$];
	sbr_exp_t    mon_e;
	int          bad_count, samples_checked;
	sbr_router #(.PULSE_CYC(PC), .PERIOD_CYC(PERIOD)) DUT (
		.I_CORE_CLK(I_CORE_CLK), .I_RESET(I_RESET), .PSEL(PSEL),
		.PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
		.PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
		.I_SYNC_LINE(sync_in), .I_STAR(star), .I_REF_CLK(refclk),
		.I_OSC(osc), .I_RX_EVENT(rx_ev), .I_XCVR_EVENT(xcvr_ev),
		.O_SYNC_LINE(line_out), .O_SYNC_LINE_OE_N(oe_n),
		.O_TIMEBASE(tbase), .O_TIMEBASE_EXT(tb_ext),
		.O_REALIGN(realign), .O_START(start));
	sbr_bus_peer u_peer (.i_clk(I_CORE_CLK), .i_fire(fire), .i_line(fire_ln),
		.i_len(fire_len), .i_run(run), .o_line(peer_line));
	// the card wins a line only where it enables its driver
	assign sync_in = (~oe_n & line_out) | (oe_n & peer_line);
	initial begin
		I_CORE_CLK = 1'h0;
		forever #2.5 I_CORE_CLK = ~I_CORE_CLK;
	end
	function automatic logic [15:0] lfsr(input logic [15:0] v);
		return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
	endfunction : lfsr
	always @(posedge I_CORE_CLK) begin
		lfsr_q <= lfsr(lfsr_q);
		{star, refclk, rx_ev, xcvr_ev} <= lfsr_q[3:0];
		osc <= ~osc;
	end
	task automatic wrap_up;
		if (bad_count == 0 && samples_checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : wrap_up
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			bad_count++;
			$display("[ERR] %0t seen %h exp %h", $time, seen, exp);
		end
	endtask : chk
	always @(posedge I_CORE_CLK) begin
		if (PSEL && PENABLE && pready === 1'h1 && exp_q.size() > 0) begin
			mon_e = exp_q.pop_front();
			chk({31'h0, pslverr}, {31'h0, mon_e.err});
			if (mon_e.rd)
				chk(prdata, mon_e.data);
		end
	end
	task automatic apb(input logic wr, input logic [7:0] a,
		input logic [31:0] d, input logic err, input logic [31:0] ed);
		int n;
		exp_q.push_back(sbr_exp_t'{err, !wr && !err, ed});
		PSEL <= 1'h1;
		PWRITE <= wr;
		PADDR <= a;
		PWDATA <= d;
		@(posedge I_CORE_CLK);
		PENABLE <= 1'h1;
		n = 0;
		do begin
			@(posedge I_CORE_CLK);
			n++;
		end while (pready !== 1'h1 && n < 20);
		if (pready !== 1'h1) begin
			bad_count++;
			wrap_up();
		end
		PSEL <= 1'h0;
		PENABLE <= 1'h0;
		@(posedge I_CORE_CLK);
	endtask : apb
	task automatic do_reset;
		I_RESET <= 1'h1;
		run <= 1'h0;
		repeat (5) @(posedge I_CORE_CLK);
		I_RESET <= 1'h0;
		@(posedge I_CORE_CLK);
	endtask : do_reset
	function automatic logic [31:0] cm(input logic [3:0] s,
		input logic [2:0] sl, input logic [2:0] d, input logic [2:0] dl);
		return {15'h0000, 1'h1, 1'h0, dl, 1'h0, d, 1'h0, sl, s};
	endfunction : cm
	// a new card setup starts from reset so old routes never linger
	task automatic cmd(input logic [7:0] c, input logic [31:0] w,
		input logic err);
		if (c !== cur_cfg) begin
			do_reset();
			apb(1'h1, sbr_pkg::OFF_CFG, {24'h0, c}, 1'h0, 32'h0);
			apb(1'h0, sbr_pkg::OFF_CFG, 32'h0, 1'h0, {24'h0, c});
			cur_cfg = c;
		end
		apb(1'h1, sbr_pkg::OFF_CMD, w, err, 32'h0);
	endtask : cmd
	task automatic pulse(input logic [2:0] ln, input logic [15:0] len,
		input int settle);
		fire_ln <= ln;
		fire_len <= len;
		fire <= 1'h1;
		@(posedge I_CORE_CLK);
		fire <= 1'h0;
		repeat (settle) @(posedge I_CORE_CLK);
	endtask : pulse
	function automatic logic pick(input logic [1:0] sel);
		return (sel == 2'h0) ? start : (sel == 2'h1) ? tb_ext : realign;
	endfunction : pick
	task automatic wait_hi(input logic [1:0] sel);
		int n;
		n = 0;
		while (pick(sel) !== 1'h1 && n < 400) begin
			@(posedge I_CORE_CLK);
			n++;
		end
		chk({31'h0, pick(sel)}, 32'h1);
		if (n >= 400)
			wrap_up();
	endtask : wait_hi
	initial begin
		{PSEL, PENABLE, PWRITE, fire, run, osc} = 6'h00;
		{star, refclk, rx_ev, xcvr_ev} = 4'h0;
		{PADDR, PWDATA, fire_ln, fire_len} = 59'h0;
		{I_RESET, lfsr_q, bad_count, samples_checked} = {1'h1, 16'hB71D, 64'h0};
		do_reset();
		apb(1'h0, sbr_pkg::OFF_CFG, 32'h0, 1'h0, sbr_pkg::CFG_RESET);
		apb(1'h0, 8'h20, 32'h0, 1'h1, 32'h0);
		cur_cfg = 8'h00;
		for (int i = 0; i < 5; i++)
			cmd(8'h00, cm(4'h5, 3'(i), 3'h0, 3'(i)), i == 4);
		cmd(8'h00, cm(4'h0, 3'h1, 3'h0, 3'h5), 1'h1);
		cmd(8'h00, cm(4'h4, 3'h0, 3'h1, 3'h7), 1'h1);
		cmd(8'h00, cm(4'h1, 3'h7, 3'h2, 3'h0), 1'h1);
		cmd(8'h00, cm(4'h0, 3'h6, 3'h4, 3'h0) | 32'h8000_0000, 1'h1);
		cmd(8'h00, cm(4'h0, 3'h6, 3'h4, 3'h0), 1'h0);
		pulse(3'h6, 16'(PC / 4), PC / 4 + 40);
		chk({31'h0, start}, 32'h0);
		repeat (PERIOD) @(posedge I_CORE_CLK);
		pulse(3'h6, 16'(2 * PC), 2 * PC + 40);
		wait_hi(2'h0);
		cmd(8'h00, cm(4'h0, 3'h5, 3'h3, 3'h0), 1'h0);
		pulse(3'h5, 16'(2 * PC), 0);
		wait_hi(2'h2);
		@(posedge I_CORE_CLK);
		chk({31'h0, realign}, 32'h0);
		chk({31'h0, line_out[0]}, 32'h1);
		for (int i = 0; i < 4; i++)
			cmd(8'h02, cm(4'h5, 3'h0, 3'h0, 3'(i)), i == 3);
		cmd(8'h10, cm(4'h5, 3'h0, 3'h0, 3'h6), 1'h1);
		cmd(8'h01, cm(4'h3, 3'h0, 3'h2, 3'h0), 1'h1);
		cmd(8'h01, cm(4'h7, 3'h0, 3'h0, 3'h1), 1'h1);
		cmd(8'h01, cm(4'h7, 3'h0, 3'h0, 3'h0), 1'h0);
		cmd(8'h01, cm(4'h4, 3'h0, 3'h1, 3'h7), 1'h0);
		cmd(8'h01, cm(4'h6, 3'h0, 3'h4, 3'h0), 1'h0);
		cmd(8'h25, cm(4'h7, 3'h0, 3'h0, 3'h0), 1'h1);
		cmd(8'h25, cm(4'h7, 3'h0, 3'h0, 3'h3), 1'h0);
		cmd(8'h25, cm(4'h5, 3'h0, 3'h0, 3'h4), 1'h1);
		cmd(8'h25, cm(4'h2, 3'h0, 3'h4, 3'h0), 1'h1);
		cmd(8'h25, cm(4'h4, 3'h0, 3'h1, 3'h7), 1'h1);
		chk({31'h0, tb_ext}, 32'h0);
		tb_seen = tbase;
		@(posedge I_CORE_CLK);
		chk({31'h0, tbase}, {31'h0, ~tb_seen});
		run <= 1'h1;
		cmd(8'h25, cm(4'h1, 3'h7, 3'h2, 3'h0), 1'h0);
		wait_hi(2'h1);
		cmd(8'h11, cm(4'h2, 3'h0, 3'h4, 3'h0), 1'h0);
		wait_hi(2'h0);
		cmd(8'h11, cm(4'h3, 3'h0, 3'h2, 3'h0), 1'h0);
		wrap_up();
	end
endmodule : testbench
`default_nettype wire
